//--- verilog/stc_defs.svh
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

// Register offsets (byte addresses)
`define STC_REG_STATUS      8'h00
`define STC_REG_MASK        8'h04
`define STC_REG_MODE        8'h08

// Status and mask bit positions
`define STC_BIT_PATTERN_ERR 0
`define STC_BIT_TRAIN_START 1
`define STC_BIT_IDLE_START  2

// Reset values
`define STC_STATUS_RESET    3'h0
`define STC_MASK_RESET      3'h0
`define STC_FLOAT_RESET     1'h0

// Credit unit in bytes, kept as a modulo-16 fill count
`define STC_CREDIT_BYTES    16
`define STC_FILL_W          4

// Link lanes
`define STC_LANES           16

`endif

//--- verilog/stc_pkg.sv
package stc_pkg;

   // Link transmit mode chosen at each burst boundary
   typedef enum logic [2:0] {
      STC_MODE_DATA  = 3'b001,
      STC_MODE_IDLE  = 3'b010,
      STC_MODE_TRAIN = 3'b100
   } stc_mode_t;

   // Packet information that travels with each stored word
   typedef struct packed {
      logic [7:0] channel;
      logic       end_marker;
      logic [2:0] byte_count;
   } stc_wr_info_t;

endpackage

//--- verilog/stc_top.sv
`timescale 1ns/1ps
`include "stc_defs.svh"

// What this block does
// - Flag error when burst without end marker stops off a 16-byte credit boundary.
// - Flag error when a write has non-zero final byte count without end marker.
// - Error flag is active high, one clock pulse per illegal write.
// - Idle request makes the link send idle words from next burst boundary.
// - Idle beats normal data but loses to a pending training request.
// - Idle request leaves FIFO contents and write-port behaviour untouched.
// - Training request makes the link send training from next burst boundary.
// - Training beats both idle requests and normal data.
// - Training request leaves FIFO contents and write-port behaviour untouched.
// - Float enable high releases link clock, 16 lanes and control flag drivers.
// - Float enable defaults to 0, so the link outputs are driven.
// - Every write-port signal is sampled or launched on the rising clock edge.
// - Low write strobe at a rising edge stores the presented word and information.
// - Word width is 32 or 64 bits; byte count is 2 or 3 bits.
module stc_top
   import stc_pkg::*;
#(
   parameter int  DATA_WIDTH = 32,
   localparam int CNT_W      = (DATA_WIDTH == 64) ? 3 : 2
)
(
   // Clock and reset
   input  wire logic                    CLK_SYS,
   input  wire logic                    RESETN,
   // User write port
   input  wire logic                    WRITE_PORT_STROBE_N,
   input  wire logic [7:0]              WRITE_CHANNEL_NUMBER,
   input  wire logic [DATA_WIDTH-1:0]   WRITE_PORT_WORD,
   input  wire logic [CNT_W-1:0]        FINAL_WORD_BYTE_COUNT,
   input  wire logic                    PACKET_END_MARKER,
   output logic                         DATA_PATTERN_ERROR_FLAG,
   // Insert requests and link control
   input  wire logic                    IDLE_INSERT_REQUEST,
   input  wire logic                    TRAINING_INSERT_REQUEST,
   input  wire logic                    LINK_OUTPUT_FLOAT_ENABLE,
   input  wire logic                    BURST_BOUNDARY,
   output stc_mode_t                    LINK_MODE,
   output logic                         LINK_DATA_CLOCK_OE,
   output logic [`STC_LANES-1:0]        LINK_DATA_LANES_OE,
   output logic                         LINK_CONTROL_FLAG_OE,
   // Transmit FIFO write side
   output logic                         FIFO_WR_EN,
   output logic [DATA_WIDTH-1:0]        FIFO_WR_WORD,
   output stc_wr_info_t                 FIFO_WR_INFO,
   // Register port
   input  wire logic [7:0]              REG_ADDR,
   input  wire logic [31:0]             REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output logic [31:0]                  REG_RDATA,
   output logic                         IRQ
);

   // Four or eight bytes per word; both divide the credit, so the fill never skips zero
   localparam logic [`STC_FILL_W-1:0] WORD_BYTES = `STC_FILL_W'(DATA_WIDTH / 8);

   logic                   wr_take;

   // Pattern checker state
   logic [`STC_FILL_W-1:0] fill_reg;
   logic [`STC_FILL_W-1:0] fill_next;
   logic [7:0]             chan_reg;
   logic [7:0]             chan_next;
   logic                   open_reg;
   logic                   open_next;
   logic                   perr_reg;
   logic                   perr_next;

   // FIFO write stage
   logic                   fwe_reg;
   logic                   fwe_next;
   logic [DATA_WIDTH-1:0]  fword_reg;
   logic [DATA_WIDTH-1:0]  fword_next;
   stc_wr_info_t           finfo_reg;
   stc_wr_info_t           finfo_next;

   // Link mode and driver enables
   stc_mode_t              mode_reg;
   stc_mode_t              mode_next;
   logic                   clk_oe_reg;
   logic                   clk_oe_next;
   logic [`STC_LANES-1:0]  lanes_oe_reg;
   logic [`STC_LANES-1:0]  lanes_oe_next;
   logic                   ctl_oe_reg;
   logic                   ctl_oe_next;

   // Registers and interrupt
   logic [2:0]             status_reg;
   logic [2:0]             status_next;
   logic [2:0]             mask_reg;
   logic [2:0]             mask_next;
   logic [31:0]            rdata_reg;
   logic [31:0]            rdata_next;
   logic                   irq_reg;
   logic                   irq_next;
   logic [2:0]             events;
   logic                   clr_status;

   // Strobe already lives in this clock domain, so no synchroniser is needed
   assign wr_take = ~WRITE_PORT_STROBE_N;

   // Pattern checker; bursts are delimited per channel, so a channel switch ends one
   always_comb
   begin
      fill_next = fill_reg;
      chan_next = chan_reg;
      open_next = open_reg;
      perr_next = 1'b0;
      if (wr_take)
      begin
         // A channel switch closes the open burst, which must end on a credit boundary
         if (open_reg && (WRITE_CHANNEL_NUMBER != chan_reg) && (fill_reg != '0))
            perr_next = 1'b1;
         if (!PACKET_END_MARKER && (FINAL_WORD_BYTE_COUNT != '0))
            perr_next = 1'b1;

         chan_next = WRITE_CHANNEL_NUMBER;
         if (PACKET_END_MARKER)
         begin
            fill_next = '0;
            open_next = 1'b0;
         end
         else
         begin
            // Four-bit fill wraps modulo the 16-byte credit
            if (open_reg && (WRITE_CHANNEL_NUMBER == chan_reg))
               fill_next = fill_reg + WORD_BYTES;
            else
               fill_next = WORD_BYTES;
            open_next = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         fill_reg <= '0;
         chan_reg <= 8'h00;
         open_reg <= 1'b0;
         perr_reg <= 1'b0;
      end
      else
      begin
         fill_reg <= fill_next;
         chan_reg <= chan_next;
         open_reg <= open_next;
         perr_reg <= perr_next;
      end
   end

   // Write stage ignores the insert requests entirely
   always_comb
   begin
      fwe_next              = wr_take;
      fword_next            = wr_take ? WRITE_PORT_WORD : fword_reg;
      finfo_next            = finfo_reg;
      if (wr_take)
      begin
         finfo_next.channel    = WRITE_CHANNEL_NUMBER;
         finfo_next.end_marker = PACKET_END_MARKER;
         // Zero-extended so both word widths share one info layout
         finfo_next.byte_count = 3'(FINAL_WORD_BYTE_COUNT);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         fwe_reg   <= 1'b0;
         fword_reg <= '0;
         finfo_reg <= '0;
      end
      else
      begin
         fwe_reg   <= fwe_next;
         fword_reg <= fword_next;
         finfo_reg <= finfo_next;
      end
   end

   // Mode only changes at a burst boundary so a burst is never cut short
   always_comb
   begin
      mode_next = mode_reg;
      if (BURST_BOUNDARY)
      begin
         if (TRAINING_INSERT_REQUEST)
            mode_next = STC_MODE_TRAIN;
         else if (IDLE_INSERT_REQUEST)
            mode_next = STC_MODE_IDLE;
         else
            mode_next = STC_MODE_DATA;
      end
      // Enables are registered like every output, so floating lags the pin by one cycle
      clk_oe_next   = ~LINK_OUTPUT_FLOAT_ENABLE;
      ctl_oe_next   = ~LINK_OUTPUT_FLOAT_ENABLE;
   end

   // One enable per lane so each lane buffer can take its own flop
   for (genvar lane = 0; lane < `STC_LANES; lane++)
   begin : g_lane_oe
      assign lanes_oe_next[lane] = ~LINK_OUTPUT_FLOAT_ENABLE;
   end

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         mode_reg     <= STC_MODE_DATA;
         clk_oe_reg   <= ~`STC_FLOAT_RESET;
         lanes_oe_reg <= {`STC_LANES{~`STC_FLOAT_RESET}};
         ctl_oe_reg   <= ~`STC_FLOAT_RESET;
      end
      else
      begin
         mode_reg     <= mode_next;
         clk_oe_reg   <= clk_oe_next;
         lanes_oe_reg <= lanes_oe_next;
         ctl_oe_reg   <= ctl_oe_next;
      end
   end

   // Events that set the sticky status bits
   assign events[`STC_BIT_PATTERN_ERR] = perr_next;
   assign events[`STC_BIT_TRAIN_START] = (mode_next == STC_MODE_TRAIN)
                                         && (mode_reg != STC_MODE_TRAIN);
   assign events[`STC_BIT_IDLE_START]  = (mode_next == STC_MODE_IDLE)
                                         && (mode_reg != STC_MODE_IDLE);
   assign clr_status = REG_WR && (REG_ADDR == `STC_REG_STATUS);

   // Per status bit: writing one clears it, but an event in the same cycle wins
   for (genvar sb = 0; sb < 3; sb++)
   begin : g_status
      assign status_next[sb] = events[sb] | (status_reg[sb] & ~(clr_status & REG_WDATA[sb]));
   end

   // Mask, read-back and interrupt
   always_comb
   begin
      mask_next   = mask_reg;
      if (REG_WR && (REG_ADDR == `STC_REG_MASK))
         mask_next = REG_WDATA[2:0];

      // Outside its read cycle the port returns zero, so a stale word is never seen
      rdata_next  = 32'h0000_0000;
      if (REG_RD)
      begin
         unique case (REG_ADDR)
            `STC_REG_STATUS: rdata_next = {29'h0000_0000, status_reg};
            `STC_REG_MASK:   rdata_next = {29'h0000_0000, mask_reg};
            `STC_REG_MODE:   rdata_next = {29'h0000_0000, mode_reg};
            default:         rdata_next = 32'h0000_0000;
         endcase
      end

      // Next-state terms keep the interrupt in step with the status it reports
      irq_next = |(status_next & mask_next);
   end

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         status_reg <= `STC_STATUS_RESET;
         mask_reg   <= `STC_MASK_RESET;
         rdata_reg  <= 32'h0000_0000;
         irq_reg    <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         mask_reg   <= mask_next;
         rdata_reg  <= rdata_next;
         irq_reg    <= irq_next;
      end
   end

   // Every output comes straight from a flop
   assign DATA_PATTERN_ERROR_FLAG = perr_reg;
   assign LINK_MODE               = mode_reg;
   assign LINK_DATA_CLOCK_OE      = clk_oe_reg;
   assign LINK_DATA_LANES_OE      = lanes_oe_reg;
   assign LINK_CONTROL_FLAG_OE    = ctl_oe_reg;
   assign FIFO_WR_EN              = fwe_reg;
   assign FIFO_WR_WORD            = fword_reg;
   assign FIFO_WR_INFO            = finfo_reg;
   assign REG_RDATA               = rdata_reg;
   assign IRQ                     = irq_reg;

endmodule

//--- test/stc_chk.sv
`timescale 1ns/1ps
`include "stc_defs.svh"
module stc_chk
   import stc_pkg::*;
#(
   parameter int  DATA_WIDTH = 32,
   localparam int CNT_W      = (DATA_WIDTH == 64) ? 3 : 2
)
(
   // Clock and reset
   input wire logic                  CLK_SYS,
   input wire logic                  RESETN,
   // Write port
   input wire logic                  WRITE_PORT_STROBE_N,
   input wire logic [DATA_WIDTH-1:0] WRITE_PORT_WORD,
   input wire logic [CNT_W-1:0]      FINAL_WORD_BYTE_COUNT,
   input wire logic                  PACKET_END_MARKER,
   input wire logic                  DATA_PATTERN_ERROR_FLAG,
   input wire logic                  FIFO_WR_EN,
   input wire logic [DATA_WIDTH-1:0] FIFO_WR_WORD,
   // Link control
   input wire logic                  IDLE_INSERT_REQUEST,
   input wire logic                  TRAINING_INSERT_REQUEST,
   input wire logic                  LINK_OUTPUT_FLOAT_ENABLE,
   input wire logic                  BURST_BOUNDARY,
   input stc_mode_t                  LINK_MODE,
   input wire logic                  LINK_DATA_CLOCK_OE,
   input wire logic [`STC_LANES-1:0] LINK_DATA_LANES_OE,
   input wire logic                  LINK_CONTROL_FLAG_OE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   AST_WR_STORE: assert property (!WRITE_PORT_STROBE_N |=> FIFO_WR_EN
      && FIFO_WR_WORD == $past(WRITE_PORT_WORD)) else $error("write not stored");
   AST_WR_NONE: assert property (WRITE_PORT_STROBE_N |=> !FIFO_WR_EN)
      else $error("store without write");
   AST_CNT_ERR: assert property (!WRITE_PORT_STROBE_N && !PACKET_END_MARKER
      && FINAL_WORD_BYTE_COUNT != 0 |=> DATA_PATTERN_ERROR_FLAG) else $error("count error missed");
   AST_ERR_PULSE: assert property (DATA_PATTERN_ERROR_FLAG |-> FIFO_WR_EN)
      else $error("error flag without write");
   AST_TRAIN: assert property (BURST_BOUNDARY && TRAINING_INSERT_REQUEST
      |=> LINK_MODE == STC_MODE_TRAIN) else $error("training not entered");
   AST_IDLE: assert property (BURST_BOUNDARY && IDLE_INSERT_REQUEST
      && !TRAINING_INSERT_REQUEST |=> LINK_MODE == STC_MODE_IDLE) else $error("idle not entered");
   AST_DATA: assert property (BURST_BOUNDARY && !IDLE_INSERT_REQUEST
      && !TRAINING_INSERT_REQUEST |=> LINK_MODE == STC_MODE_DATA) else $error("data not resumed");
   AST_HOLD: assert property (!BURST_BOUNDARY |=> $stable(LINK_MODE))
      else $error("mode changed off boundary");
   AST_FLOAT: assert property (LINK_OUTPUT_FLOAT_ENABLE |=> !LINK_DATA_CLOCK_OE
      && LINK_DATA_LANES_OE == '0 && !LINK_CONTROL_FLAG_OE) else $error("link not floated");
   AST_DRIVE: assert property (!LINK_OUTPUT_FLOAT_ENABLE |=> LINK_DATA_CLOCK_OE
      && &LINK_DATA_LANES_OE && LINK_CONTROL_FLAG_OE) else $error("link not driven");
endmodule

bind stc_top stc_chk #(.DATA_WIDTH(DATA_WIDTH)) u_chk (.CLK_SYS, .RESETN,
   .WRITE_PORT_STROBE_N, .WRITE_PORT_WORD, .FINAL_WORD_BYTE_COUNT, .PACKET_END_MARKER,
   .DATA_PATTERN_ERROR_FLAG, .FIFO_WR_EN, .FIFO_WR_WORD, .IDLE_INSERT_REQUEST,
   .TRAINING_INSERT_REQUEST, .LINK_OUTPUT_FLOAT_ENABLE, .BURST_BOUNDARY, .LINK_MODE,
   .LINK_DATA_CLOCK_OE, .LINK_DATA_LANES_OE, .LINK_CONTROL_FLAG_OE);

//--- test/stc_writer.sv
`timescale 1ns/1ps
module stc_writer
(
   // Clock
   input  wire logic        clk,
   // Write port toward the block
   output logic             strobe_n,
   output logic [7:0]       chan,
   output logic [31:0]      word,
   output logic [1:0]       cnt,
   output logic             eop
);
   initial
   begin
      strobe_n = 1'b1;
      chan = 8'h00;
      word = 32'h0;
      cnt = 2'h0;
      eop = 1'b0;
   end
   task automatic put(input logic [7:0] c, input logic [31:0] w, input logic e,
                      input logic [1:0] n);
      begin
         @(posedge clk);
         strobe_n <= 1'b0;
         chan <= c;
         word <= w;
         eop <= e;
         cnt <= n;
         @(posedge clk);
         strobe_n <= 1'b1;
         // Released lines show garbage, never the last value
         chan <= ~c;
         word <= ~w;
         cnt <= ~n;
         eop <= ~e;
         #1;
      end
   endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
`include "stc_defs.svh"
module testbench import stc_pkg::*;;
   logic clk_sys = 1'b0, rst_n = 1'b0, idle = 1'b0, train = 1'b0, flt = 1'b0, bb = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, err, clk_oe, ctl_oe, wr_en, irq, strobe_n, eop;
   logic [7:0]  reg_addr = 8'h00, chan;
   logic [31:0] reg_wdata = 32'h0, word, wr_word, rdata;
   logic [1:0]  cnt;
   logic [15:0] lanes_oe;
   stc_mode_t    link_mode;
   stc_wr_info_t wr_info;
   int checked = 0, fail_count = 0;
   always #12.5 clk_sys = ~clk_sys;
   stc_writer wr (.clk(clk_sys), .strobe_n(strobe_n), .chan(chan), .word(word),
      .cnt(cnt), .eop(eop));
   stc_top #(.DATA_WIDTH(32)) uut (.CLK_SYS(clk_sys), .RESETN(rst_n),
      .WRITE_PORT_STROBE_N(strobe_n), .WRITE_CHANNEL_NUMBER(chan), .WRITE_PORT_WORD(word),
      .FINAL_WORD_BYTE_COUNT(cnt), .PACKET_END_MARKER(eop), .DATA_PATTERN_ERROR_FLAG(err),
      .IDLE_INSERT_REQUEST(idle), .TRAINING_INSERT_REQUEST(train),
      .LINK_OUTPUT_FLOAT_ENABLE(flt), .BURST_BOUNDARY(bb), .LINK_MODE(link_mode),
      .LINK_DATA_CLOCK_OE(clk_oe), .LINK_DATA_LANES_OE(lanes_oe),
      .LINK_CONTROL_FLAG_OE(ctl_oe), .FIFO_WR_EN(wr_en), .FIFO_WR_WORD(wr_word),
      .FIFO_WR_INFO(wr_info), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(rdata), .IRQ(irq));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      begin
         checked++;
         if (got !== exp)
         begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
         end
      end
   endtask
   task automatic tally_and_finish;
      begin
         $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk_sys);
         reg_wr <= w;
         reg_rd <= !w;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         #1;
      end
   endtask
   task automatic put_chk(input logic [7:0] c, input logic e, input logic [1:0] n,
                          input logic exp_err);
      begin
         wr.put(c, {24'h5A5A00, c}, e, n);
         chk("store", 32'h1, 32'(wr_en));
         chk("word", {24'h5A5A00, c}, wr_word);
         chk("info", {20'h0, c, e, 1'b0, n}, 32'(wr_info));
         chk("pattern error", 32'(exp_err), 32'(err));
      end
   endtask
   task automatic t_mode(input logic tr, input logic id, input stc_mode_t exp);
      begin
         @(posedge clk_sys);
         train <= tr;
         idle <= id;
         bb <= 1'b1;
         @(posedge clk_sys);
         bb <= 1'b0;
         #1;
         chk("mode", 32'(exp), 32'(link_mode));
         put_chk(8'h0C, 1'b1, 2'h1, 1'b0);
         chk("mode held", 32'(exp), 32'(link_mode));
         $display("mode test done");
      end
   endtask
   task automatic t_float(input logic f);
      begin
         @(posedge clk_sys);
         flt <= f;
         @(posedge clk_sys);
         #1;
         chk("drivers", f ? 32'h0 : 32'h3FFFF, 32'({clk_oe, lanes_oe, ctl_oe}));
         $display("float test done");
      end
   endtask
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end
   task automatic t_reset;
      begin
         repeat (16) @(posedge clk_sys);
         rst_n <= 1'b1;
         #1;
         chk("reset mode", 32'(STC_MODE_DATA), 32'(link_mode));
         chk("reset drivers", 32'h3FFFF, 32'({clk_oe, lanes_oe, ctl_oe}));
         chk("reset flags", 32'h0, 32'({err, wr_en, irq}));
         chk("reset read data", 32'h0, rdata);
         $display("reset test done");
      end
   endtask
   task automatic t_pattern;
      begin
         put_chk(8'h05, 1'b0, 2'h0, 1'b0);
         put_chk(8'h05, 1'b1, 2'h2, 1'b0);
         put_chk(8'h03, 1'b0, 2'h2, 1'b1);
         @(posedge clk_sys);
         #1;
         chk("error pulse ends", 32'h0, 32'(err));
         put_chk(8'h03, 1'b1, 2'h2, 1'b0);
         for (int i = 0; i < 4; i++)
            put_chk(8'h07, 1'b0, 2'h0, 1'b0);
         put_chk(8'h08, 1'b1, 2'h0, 1'b0);
         put_chk(8'h09, 1'b0, 2'h0, 1'b0);
         put_chk(8'h0A, 1'b1, 2'h0, 1'b1);
         $display("pattern test done");
      end
   endtask
   task automatic t_regs;
      begin
         reg_op(1'b0, `STC_REG_STATUS, 32'h0);
         chk("status", 32'h7, rdata);
         chk("irq masked", 32'h0, 32'(irq));
         reg_op(1'b1, `STC_REG_MASK, 32'h1);
         chk("irq raised", 32'h1, 32'(irq));
         reg_op(1'b0, `STC_REG_MASK, 32'h0);
         chk("mask", 32'h1, rdata);
         reg_op(1'b1, `STC_REG_STATUS, 32'h1);
         chk("irq cleared", 32'h0, 32'(irq));
         reg_op(1'b0, `STC_REG_STATUS, 32'h0);
         chk("status cleared", 32'h6, rdata);
         reg_op(1'b1, 8'h10, 32'h7);
         reg_op(1'b0, 8'h10, 32'h0);
         chk("unmapped", 32'h0, rdata);
         reg_op(1'b0, `STC_REG_MODE, 32'h0);
         chk("mode reg", 32'(STC_MODE_DATA), rdata);
         $display("register test done");
      end
   endtask
   initial
   begin
      t_reset();
      t_pattern();
      t_mode(1'b0, 1'b1, STC_MODE_IDLE);
      t_mode(1'b1, 1'b1, STC_MODE_TRAIN);
      t_mode(1'b0, 1'b0, STC_MODE_DATA);
      t_float(1'b1);
      t_float(1'b0);
      t_regs();
      tally_and_finish();
   end
endmodule
